// ===== logic/bps_pkg.sv
// Package of constants, states and timing for the battery protection sequencer
package bps_pkg;
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned TICK_HZ      = 4_000;
	localparam int unsigned TICK_DIV     = CLK_HZ / TICK_HZ;
	localparam int          TW           = 16;
	// Delays in ticks of the slow clock
	localparam logic [TW-1:0] D_OV1      = 16'h0028;
	localparam logic [TW-1:0] D_OV2      = 16'h0008;
	localparam logic [TW-1:0] D_SHORT    = 16'h0001;
	localparam logic [TW-1:0] D_CHG_OV   = 16'h0020;
	localparam logic [TW-1:0] D_ODIS     = 16'h0200;
	localparam logic [TW-1:0] D_INHIBIT  = 16'h0040;
	localparam logic [TW-1:0] D_PSAVE    = 16'h0040;
	localparam logic [TW-1:0] TICK_ZERO  = 16'h0000;
	// Resistor connection codes
	localparam logic [1:0] RES_OFF       = 2'h0;
	localparam logic [1:0] RES_UP        = 2'h1;
	localparam logic [1:0] RES_DOWN      = 2'h2;

	typedef enum logic [5:0] {
		BPS_NORMAL  = 6'h01,
		BPS_DOC     = 6'h02,
		BPS_COC     = 6'h04,
		BPS_ODIS    = 6'h08,
		BPS_INHIBIT = 6'h10,
		BPS_PSAVE   = 6'h20
	} bps_state_t;
endpackage

// ===== logic/bps_tick.sv
// Slow tick generator dividing the system clock to about 4 kHz
`timescale 1ns/1ps
`default_nettype none
module bps_tick
	import bps_pkg::*;
#(
	parameter int unsigned DIV = TICK_DIV
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rstn,
	// Tick
	output logic      o_tick
);
	typedef struct packed {
		logic [TW-1:0] cnt;
		logic          tick;
	} bps_tick_st_t;
	bps_tick_st_t s_q, s_d;
	localparam logic [TW-1:0] LAST = TW'(DIV - 1);

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt == LAST) begin
			s_d.cnt = TICK_ZERO;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_tick = s_q.tick;
endmodule
`default_nettype wire

// ===== logic/bps_delay.sv
// Restartable detection delay counter in slow ticks
`timescale 1ns/1ps
`default_nettype none
module bps_delay
	import bps_pkg::*;
(
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rstn,
	// Timing
	input  wire logic          i_tick,
	input  wire logic          i_cond,
	input  wire logic [TW-1:0] i_limit,
	// Expiry
	output logic               o_done
);
	typedef struct packed {
		logic [TW-1:0] cnt;
		logic          done;
	} bps_dly_st_t;
	bps_dly_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (!i_cond) begin
			s_d.cnt = TICK_ZERO;
			s_d.done = 1'b0;
		end else if (i_tick && !s_q.done) begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_d.cnt >= i_limit)
				s_d.done = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_done = s_q.done;
endmodule
`default_nettype wire

// ===== logic/bps_seq.sv
// Status sequencer driving charge and discharge FET gate controls
`timescale 1ns/1ps
`default_nettype none
module bps_seq
	import bps_pkg::*;
#(
	// Build options fixed per device
	parameter bit HAS_PSAVE    = 1'b0,
	parameter bit ACTIVE_HIGH  = 1'b1,
	parameter bit INH_PULLUP   = 1'b1,
	parameter bit ZERO_V_EN    = 1'b1,
	parameter int unsigned DIV = TICK_DIV
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rstn,
	// Comparator results on the load-sense pin
	input  wire logic i_ls_short2,
	input  wire logic i_ls_release,
	input  wire logic i_ls_chg_release,
	input  wire logic i_ls_power_down,
	// Comparator results on the current-sense pin
	input  wire logic i_cs_ov1,
	input  wire logic i_cs_ov2,
	input  wire logic i_cs_short,
	input  wire logic i_cs_chg_ov,
	// Battery and charger comparators
	input  wire logic i_bat_below_odis,
	input  wire logic i_bat_above_inh,
	input  wire logic i_chg_zero_start,
	input  wire logic i_overcharge,
	// Control pin level comparators (inhibit or power-save)
	input  wire logic i_ctl_high,
	input  wire logic i_ctl_low,
	// FET gates, resistor switches and state
	output logic      o_chg_fet_on,
	output logic      o_dis_fet_on,
	output logic      o_chg_gate_force,
	output logic [1:0] o_ctl_res,
	output logic      o_ls_pullup2,
	output logic [5:0] o_state
);
	typedef struct packed {
		bps_state_t state;
		logic       chg_on;
		logic       dis_on;
		logic       gate_up;
		logic [1:0] res;
		logic       pull2;
	} bps_seq_st_t;
	bps_seq_st_t s_q, s_d;

	logic tick;
	logic ctl_act;
	logic ctl_rel;
	logic d_ov1_c, d_ov2_c, d_sh_c, d_s2_c;
	logic d_ov1, d_ov2, d_sh, d_s2, d_coc, d_odis, d_ctl;
	logic normal;
	logic zero_chg;
	logic [1:0] res_idle;
	logic [1:0] res_save;

	bps_tick #(.DIV(DIV)) u_tick (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.o_tick (tick)
	);

	assign normal   = (s_q.state == BPS_NORMAL);
	assign ctl_act  = ACTIVE_HIGH ? i_ctl_high : i_ctl_low;
	assign ctl_rel  = ACTIVE_HIGH ? i_ctl_low : i_ctl_high;
	// Higher levels only time once level one has been seen
	assign d_ov1_c  = normal && i_cs_ov1;
	assign d_ov2_c  = d_ov1_c && i_cs_ov2;
	assign d_sh_c   = d_ov1_c && i_cs_short;
	assign d_s2_c   = normal && i_ls_short2;
	assign zero_chg = ZERO_V_EN && i_bat_below_odis && i_chg_zero_start;

	bps_delay u_ov1 (.i_clk(i_clk), .i_rstn(i_rstn), .i_tick(tick),
		.i_cond(d_ov1_c), .i_limit(D_OV1), .o_done(d_ov1));
	bps_delay u_ov2 (.i_clk(i_clk), .i_rstn(i_rstn), .i_tick(tick),
		.i_cond(d_ov2_c), .i_limit(D_OV2), .o_done(d_ov2));
	bps_delay u_sh (.i_clk(i_clk), .i_rstn(i_rstn), .i_tick(tick),
		.i_cond(d_sh_c), .i_limit(D_SHORT), .o_done(d_sh));
	bps_delay u_s2 (.i_clk(i_clk), .i_rstn(i_rstn), .i_tick(tick),
		.i_cond(d_s2_c), .i_limit(D_SHORT), .o_done(d_s2));
	// Charge overcurrent masked below threshold and in overdischarge
	bps_delay u_coc (.i_clk(i_clk), .i_rstn(i_rstn), .i_tick(tick),
		.i_cond(normal && i_cs_chg_ov && !i_bat_below_odis),
		.i_limit(D_CHG_OV), .o_done(d_coc));
	bps_delay u_odis (.i_clk(i_clk), .i_rstn(i_rstn), .i_tick(tick),
		.i_cond(normal && i_bat_below_odis), .i_limit(D_ODIS), .o_done(d_odis));
	// Control pin timer ignored in overdischarge, and in overcharge only when HAS_PSAVE is set
	bps_delay u_ctl (.i_clk(i_clk), .i_rstn(i_rstn), .i_tick(tick),
		.i_cond(normal && ctl_act && !(HAS_PSAVE && i_overcharge)),
		.i_limit(HAS_PSAVE ? D_PSAVE : D_INHIBIT), .o_done(d_ctl));

	// Resistor connection when idle and when saving; active-high power-save builds idle pulled down
	always_comb begin
		if (HAS_PSAVE) begin
			res_idle = ACTIVE_HIGH ? RES_DOWN : RES_UP;
			res_save = ACTIVE_HIGH ? RES_UP : RES_DOWN;
		end else begin
			res_idle = INH_PULLUP ? RES_UP : RES_DOWN;
			res_save = res_idle;
		end
	end

	always_comb begin
		s_d = s_q;
		case (s_q.state)
			BPS_NORMAL: begin
				if (d_odis)
					s_d.state = BPS_ODIS;
				else if (d_ov1 || d_ov2 || d_sh || d_s2)
					s_d.state = BPS_DOC;
				else if (d_coc)
					s_d.state = BPS_COC;
				else if (d_ctl)
					s_d.state = HAS_PSAVE ? BPS_PSAVE : BPS_INHIBIT;
			end
			BPS_DOC: begin
				if (i_ls_release)
					s_d.state = BPS_NORMAL;
			end
			BPS_COC: begin
				if (i_ls_chg_release)
					s_d.state = BPS_NORMAL;
			end
			BPS_ODIS: begin
				if (!i_bat_below_odis)
					s_d.state = BPS_NORMAL;
			end
			BPS_INHIBIT: begin
				if (ctl_rel)
					s_d.state = BPS_NORMAL;
			end
			BPS_PSAVE: begin
				if (ctl_rel)
					s_d.state = BPS_NORMAL;
			end
			default: s_d.state = BPS_NORMAL;
		endcase

		// Outputs follow the next state so they settle with it
		s_d.dis_on = (s_d.state == BPS_NORMAL) || (s_d.state == BPS_COC);
		s_d.chg_on = (s_d.state == BPS_NORMAL) || (s_d.state == BPS_DOC)
			|| (s_d.state == BPS_ODIS);
		if (!ZERO_V_EN && !i_bat_above_inh)
			s_d.chg_on = 1'b0;
		s_d.gate_up = zero_chg;
		if (zero_chg)
			s_d.chg_on = 1'b1;
		s_d.pull2 = (s_d.state == BPS_PSAVE);
		s_d.res = (s_d.state == BPS_PSAVE) ? res_save : res_idle;
		if ((s_d.state == BPS_ODIS) && i_ls_power_down)
			s_d.res = RES_OFF;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			s_q.state  <= BPS_NORMAL;
			s_q.chg_on <= 1'b1;
			s_q.dis_on <= 1'b1;
			s_q.gate_up <= 1'b0;
			s_q.res    <= RES_OFF;
			s_q.pull2  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_chg_fet_on     = s_q.chg_on;
	assign o_dis_fet_on     = s_q.dis_on;
	assign o_chg_gate_force = s_q.gate_up;
	assign o_ctl_res        = s_q.res;
	assign o_ls_pullup2     = s_q.pull2;
	assign o_state          = s_q.state;
endmodule
`default_nettype wire

// ===== tb/bps_seq_chk.sv
// Port assertions for the status sequencer
`timescale 1ns/1ps
`default_nettype none
module bps_seq_chk
	import bps_pkg::*;
#(
	parameter bit ACTIVE_HIGH = 1'b1
) (
	// Clock and reset
	input wire logic       i_clk,
	input wire logic       i_rstn,
	// Comparator inputs
	input wire logic       i_ls_short2,
	input wire logic       i_ls_release,
	input wire logic       i_ls_chg_release,
	input wire logic       i_bat_below_odis,
	input wire logic       i_ctl_high,
	input wire logic       i_ctl_low,
	// Outputs watched
	input wire logic       o_chg_fet_on,
	input wire logic       o_dis_fet_on,
	input wire logic [5:0] o_state
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic rel_ctl;
	assign rel_ctl = ACTIVE_HIGH ? i_ctl_low : i_ctl_high;
	sequence s_short_held;
		(o_state == BPS_NORMAL && i_ls_short2 && !i_bat_below_odis) [*8];
	endsequence
	sequence s_normal;
		o_state == BPS_NORMAL && o_dis_fet_on && o_chg_fet_on;
	endsequence
	// Short delay is one slow tick, so eleven clocks at a fast divider is late
	property p_short;
		s_short_held |-> ##[0:3] (o_state != BPS_NORMAL || !i_ls_short2);
	endproperty
	a_short: assert property (p_short) else $error("short trip late");
	property p_doc;
		o_state == BPS_DOC |-> !o_dis_fet_on && o_chg_fet_on;
	endproperty
	a_doc: assert property (p_doc) else $error("discharge gate wrong");
	property p_doc_rel;
		o_state == BPS_DOC && i_ls_release |=> s_normal;
	endproperty
	a_doc_rel: assert property (p_doc_rel) else $error("no overcurrent release");
	property p_coc;
		o_state == BPS_COC |-> !o_chg_fet_on && o_dis_fet_on;
	endproperty
	a_coc: assert property (p_coc) else $error("charge gate wrong");
	property p_coc_rel;
		o_state == BPS_COC && i_ls_chg_release |=> s_normal;
	endproperty
	a_coc_rel: assert property (p_coc_rel) else $error("no charge release");
	property p_odis;
		o_state == BPS_ODIS && i_bat_below_odis |=> o_state == BPS_ODIS && !o_dis_fet_on;
	endproperty
	a_odis: assert property (p_odis) else $error("overdischarge left");
	property p_inh;
		o_state == BPS_INHIBIT |-> !o_chg_fet_on && !o_dis_fet_on;
	endproperty
	a_inh: assert property (p_inh) else $error("inhibit gates on");
	property p_inh_rel;
		o_state == BPS_INHIBIT && rel_ctl |=> s_normal;
	endproperty
	a_inh_rel: assert property (p_inh_rel) else $error("no inhibit release");
endmodule
bind bps_seq bps_seq_chk #(.ACTIVE_HIGH(ACTIVE_HIGH)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_ls_short2(i_ls_short2), .i_ls_release(i_ls_release),
	.i_ls_chg_release(i_ls_chg_release), .i_bat_below_odis(i_bat_below_odis),
	.i_ctl_high(i_ctl_high), .i_ctl_low(i_ctl_low), .o_chg_fet_on(o_chg_fet_on),
	.o_dis_fet_on(o_dis_fet_on), .o_state(o_state));
`default_nettype wire

// ===== tb/bps_pack.sv
// Pack model: load, charger and control pin seen through comparators
`timescale 1ns/1ps
`default_nettype none
module bps_pack (
	// Scenario controls
	input  wire logic [1:0] i_load,
	input  wire logic [1:0] i_chg,
	input  wire logic       i_ctl,
	// Comparator results
	output logic            o_ls_short2,
	output logic            o_ls_release,
	output logic            o_ls_chg_release,
	output logic            o_cs_ov1,
	output logic            o_cs_ov2,
	output logic            o_cs_chg_ov,
	output logic            o_chg_zero_start,
	output logic            o_ctl_high,
	output logic            o_ctl_low
);
	// Load 1 heavy, 2 shorted, 3 level-two overcurrent; charger 2 pushes excess current
	assign o_cs_ov1 = i_load != 2'h0;
	assign o_cs_ov2 = i_load == 2'h3;
	assign o_ls_short2 = i_load == 2'h2;
	// Load-sense falls back only with load and charger both gone
	assign o_ls_release = i_load == 2'h0 && i_chg == 2'h0;
	assign o_ls_chg_release = i_load != 2'h0 && i_chg == 2'h0;
	assign o_cs_chg_ov = i_chg == 2'h2;
	assign o_chg_zero_start = i_chg != 2'h0;
	assign o_ctl_high = i_ctl;
	assign o_ctl_low = !i_ctl;
endmodule
`default_nettype wire

// ===== tb/bps_tb.sv
// Self-checking bench for the status sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import bps_pkg::*;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [1:0] load = 2'h0;
	logic [1:0] chg = 2'h0;
	logic       ctl = 1'b0;
	logic       bat_low = 1'b0;
	logic       pdn = 1'b0;
	logic       ov2, pull2;
	logic [1:0] res;
	logic       sh2, rel, crel, ov1, cov, zst, chi, clo, chg_on, dis_on, frc;
	logic [5:0] st;
	int         bad_count = 0;
	int         samples_checked = 0;
	always #25 clk = ~clk;
	bps_pack i_pack (.i_load(load), .i_chg(chg), .i_ctl(ctl), .o_ls_short2(sh2),
		.o_ls_release(rel), .o_ls_chg_release(crel), .o_cs_ov1(ov1), .o_cs_chg_ov(cov),
		.o_chg_zero_start(zst), .o_ctl_high(chi), .o_ctl_low(clo), .o_cs_ov2(ov2));
	// Fast divider keeps the long overdischarge delay short
	bps_seq #(.DIV(4)) i_dut (.i_clk(clk), .i_rstn(rstn), .i_ls_short2(sh2),
		.i_ls_release(rel), .i_ls_chg_release(crel), .i_ls_power_down(pdn),
		.i_cs_ov1(ov1), .i_cs_ov2(ov2), .i_cs_short(1'b0), .i_cs_chg_ov(cov),
		.i_bat_below_odis(bat_low), .i_bat_above_inh(1'b1), .i_chg_zero_start(zst),
		.i_overcharge(1'b0), .i_ctl_high(chi), .i_ctl_low(clo), .o_chg_fet_on(chg_on),
		.o_dis_fet_on(dis_on), .o_chg_gate_force(frc), .o_ctl_res(res), .o_ls_pullup2(pull2),
		.o_state(st));
	task chk(input string nm, input logic [5:0] exp, input logic [5:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wst(input logic [5:0] exp, input int n);
		int k;
		k = 0;
		while (st !== exp && k < n) begin
			@(negedge clk);
			k++;
		end
		chk("state", exp, st);
	endtask
	task back;
		pdn = 1'b0;
		load = 2'h0;
		chg = 2'h0;
		ctl = 1'b0;
		bat_low = 1'b0;
		repeat (2) @(negedge clk);
		chk("release", BPS_NORMAL, st);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task t_ov;
		load = 2'h1;
		repeat (150) @(negedge clk);
		chk("early", BPS_NORMAL, st);
		wst(BPS_DOC, 30);
		chk("gates", 6'h02, 6'({chg_on, dis_on}));
		back;
		$display("test overcurrent done");
	endtask
	task t_ov2;
		load = 2'h3;
		repeat (20) @(negedge clk);
		chk("early2", BPS_NORMAL, st);
		wst(BPS_DOC, 30);
		chk("gates2", 6'h02, 6'({chg_on, dis_on}));
		back;
		$display("test overcurrent two done");
	endtask
	task t_short;
		load = 2'h2;
		wst(BPS_DOC, 12);
		back;
		$display("test short done");
	endtask
	task t_coc;
		chg = 2'h2;
		wst(BPS_COC, 140);
		chk("gates", 6'h01, 6'({chg_on, dis_on}));
		chg = 2'h0;
		load = 2'h1;
		repeat (2) @(negedge clk);
		chk("charge release", BPS_NORMAL, st);
		back;
		$display("test charge overcurrent done");
	endtask
	task t_inh;
		ctl = 1'b1;
		repeat (200) @(negedge clk);
		ctl = 1'b0;
		@(negedge clk);
		ctl = 1'b1;
		repeat (200) @(negedge clk);
		chk("restart", BPS_NORMAL, st);
		wst(BPS_INHIBIT, 80);
		chk("gates", 6'h00, 6'({chg_on, dis_on}));
		chk("resistor", 6'(RES_UP), 6'(res));
		chk("pullup2", 6'h00, 6'(pull2));
		back;
		$display("test inhibit done");
	endtask
	task t_odis;
		bat_low = 1'b1;
		wst(BPS_ODIS, 2100);
		ctl = 1'b1;
		chg = 2'h2;
		pdn = 1'b1;
		repeat (300) @(negedge clk);
		chk("ignore", BPS_ODIS, st);
		chk("force", 6'h01, 6'(frc));
		chk("resistor off", 6'(RES_OFF), 6'(res));
		back;
		$display("test overdischarge done");
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		t_ov;
		t_ov2;
		t_short;
		t_coc;
		t_inh;
		t_odis;
		end_sim;
	end
	// Tests need about three thousand two hundred clocks
	initial begin
		repeat (10000) @(posedge clk);
		bad_count++;
		end_sim;
	end
endmodule
`default_nettype wire
